// file: hdl/adcim_defines.vh
`ifndef ADCIM_DEFINES_VH
`define ADCIM_DEFINES_VH
// Register addresses on the plain register port.
`define ADCIM_ADDR_CONV_CTRL 4'h0
`define ADCIM_ADDR_EVENT_MASK 4'h1
`define ADCIM_ADDR_SRC_ENABLE 4'h2
`define ADCIM_ADDR_CONTROL 4'h3
`define ADCIM_ADDR_STATUS 4'h4
`define ADCIM_ADDR_RESULT 4'h5
`define ADCIM_ADDR_MODE 4'h6
// Converter control fields.
`define ADCIM_CC_START 0
`define ADCIM_CC_POWER 2
`define ADCIM_CC_CLK_LO 3
`define ADCIM_CC_CH_LO 5
// Event mask fields.
`define ADCIM_EM_PERIOD1 4
`define ADCIM_EM_CONV_DONE 5
`define ADCIM_EM_SERIAL_RX 6
`define ADCIM_EM_PERIOD2 7
// Source enable fields.
`define ADCIM_SE_TICK 0
`define ADCIM_SE_CNT_A 1
`define ADCIM_SE_CNT_B 2
`define ADCIM_SE_EDGE0 3
`define ADCIM_SE_EDGE3 7
// Control register edge select bit.
`define ADCIM_CTL_EDGE_SEL 7
// Mode register fields.
`define ADCIM_MODE_GINT 0
`define ADCIM_MODE_LOW_SPEED 1
`define ADCIM_MODE_MASTER 2
`define ADCIM_MODE_SLOW_CLK 3
`define ADCIM_MODE_PORT_SW 4
// Reset values.
`define ADCIM_RST_ZERO 8'h00
`define ADCIM_RST_CONTROL 8'hff
// Timing.
`define ADCIM_CLK_HZ 10000000
`define ADCIM_CONV_CYCLES 12
`define ADCIM_MIN_CONV_NS 13000
`define ADCIM_MIN_CONV_CLKS ((`ADCIM_MIN_CONV_NS * (`ADCIM_CLK_HZ / 1000000) + 999) / 1000)
`define ADCIM_BASE_DIV (((`ADCIM_MIN_CONV_CLKS) + `ADCIM_CONV_CYCLES - 1) / `ADCIM_CONV_CYCLES)
`define ADCIM_VECTOR_ADDR 12'h008
`endif

// file: hdl/adcim_clk_div.v
`timescale 1ns/1ps
`default_nettype none
`include "adcim_defines.vh"
module adcim_clk_div
(
   input wire clock_i,
   input wire rst_b_i,
   input wire run_i,
   input wire [1:0] sel_i,
   output reg tick_o
);
   localparam integer base_div = `ADCIM_BASE_DIV;
   reg [7:0] cnt_q;
   wire [7:0] base;
   wire [7:0] limit;
   // The base divisor is small, so its low byte carries the whole value.
   assign base = base_div[7:0];
   assign limit = (base << sel_i) - 8'd1;
   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cnt_q <= 8'h00;
         tick_o <= 1'b0;
      end
      else if (!run_i)
      begin
         cnt_q <= 8'h00;
         tick_o <= 1'b0;
      end
      else if (cnt_q >= limit)
      begin
         cnt_q <= 8'h00;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 8'h01;
         tick_o <= 1'b0;
      end
   end
endmodule // adcim_clk_div
`default_nettype wire

// file: hdl/adcim_sar.v
`timescale 1ns/1ps
`default_nettype none
`include "adcim_defines.vh"
module adcim_sar
(
   input wire clock_i,
   input wire rst_b_i,
   input wire start_i,
   input wire tick_i,
   input wire comp_i,
   output reg [7:0] trial_o,
   output reg busy_o,
   output reg done_o,
   output reg [7:0] result_o
);
   reg [3:0] step_q;
   reg [7:0] bit_q;
   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         step_q <= 4'h0;
         bit_q <= 8'h00;
         trial_o <= 8'h00;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         result_o <= 8'h00;
      end
      else
      begin
         done_o <= 1'b0;
         if (!busy_o)
         begin
            if (start_i)
            begin
               busy_o <= 1'b1;
               step_q <= 4'h0;
               bit_q <= 8'h80;
               trial_o <= 8'h80;
            end
         end
         else if (tick_i)
         begin
            step_q <= step_q + 4'h1;
            if (step_q >= 4'h2 && step_q <= 4'h9)
            begin
               bit_q <= bit_q >> 1;
               trial_o <= (comp_i ? trial_o : (trial_o & ~bit_q)) | (bit_q >> 1);
            end
            if (step_q == 4'd`ADCIM_CONV_CYCLES - 4'd1)
            begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               result_o <= trial_o;
            end
         end
      end
   end
endmodule // adcim_sar
`default_nettype wire

// file: hdl/adcim_top.v
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "adcim_defines.vh"
// Overview of operation
// - Event mask bit 5 gates the conversion completion interrupt.
// - A conversion begins whenever conv_start and conv_power are both set and the converter is idle, except in the cycle in which a conversion ends.
// - Each conversion takes twelve converter clock cycles.
// - Shortest conversion period is 13 us.
// - With mask set, completion clears conv_start and, outside low speed, raises the interrupt.
// - Completion flag set by hardware, cleared by software.
// - With mask clear, conversion repeats, start stays set, flag stays clear.
// - Setting the mask again resumes flag setting at conversion ends.
// - conv_power low powers down converter bias circuits.
// - Result is 8-bit successive approximation, held in the result register.
// - Four channels share one sample-and-hold; reference external or supply.
// - Converter interrupt fires on the rising edge of the completion flag.
// - Mask bits 4 and 7 enable period1 and period2 interrupts.
// - Mask bit 6 enables the serial receive-full interrupt.
// - Source enable bits 0 to 3 and 7 enable their interrupts.
// - Enabled source with global enable redirects fetch to address 8.
// - Edge pin 0 triggers on the edge chosen by control bit 7.
// - Edge pin 3 triggers only on a falling edge.
// - Low speed: serial and period interrupts need master and slow clock.
// - Channel codes 010 to 101 select inputs 3 to 6, others none.
// - Sample clock select divides converter clock by 1, 2, 4 or 8.
module adcim_top
(
   input wire clock_i,
   input wire rst_b_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire comp_i,
   input wire ext_ref_i,
   input wire tick_overflow_i,
   input wire counter_a_timeout_i,
   input wire counter_b_timeout_i,
   input wire edge_pin_0_i,
   input wire edge_pin_3_i,
   input wire serial_rx_full_i,
   input wire period1_done_i,
   input wire period2_done_i,
   input wire global_int_on_i,
   input wire global_int_off_i,
   output reg [7:0] dac_trial_o,
   output reg [3:0] chan_en_o,
   output reg sample_hold_o,
   output reg bias_en_o,
   output reg ref_ext_sel_o,
   output reg port_conv_mode_o,
   output reg irq_o,
   output reg [11:0] vector_addr_o
);
   reg [7:0] conv_ctrl_q;
   reg [7:0] event_mask_q;
   reg [7:0] src_enable_q;
   reg [7:0] control_q;
   reg [7:0] status_q;
   reg [7:0] mode_q;
   reg gint_q;
   reg conv_done_q;
   reg done_prev_q;
   reg edge0_prev_q;
   reg edge3_prev_q;
   reg [7:0] flags_d;
   reg [7:0] src_d;
   reg [2:0] ch;
   wire conv_tick;
   wire sar_busy;
   wire sar_done;
   wire [7:0] sar_result;
   wire [7:0] sar_trial;
   wire mask_done;
   wire low_speed;
   wire slow_ok;
   wire sar_start;
   wire edge0_hit;
   wire edge3_hit;
   wire start_wr;
   assign mask_done = event_mask_q[`ADCIM_EM_CONV_DONE];
   assign low_speed = mode_q[`ADCIM_MODE_LOW_SPEED];
   assign slow_ok = mode_q[`ADCIM_MODE_MASTER] & mode_q[`ADCIM_MODE_SLOW_CLK];
   assign start_wr = wr_i && addr_i == `ADCIM_ADDR_CONV_CTRL;
   // A conversion starts only while powered and started; a busy SAR ignores new starts.
   assign sar_start = conv_ctrl_q[`ADCIM_CC_START] & conv_ctrl_q[`ADCIM_CC_POWER] & ~sar_done;
   assign edge0_hit = control_q[`ADCIM_CTL_EDGE_SEL] ? (~edge0_prev_q & edge_pin_0_i) :
      (edge0_prev_q & ~edge_pin_0_i);
   assign edge3_hit = edge3_prev_q & ~edge_pin_3_i;
   adcim_clk_div u_div
   (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .run_i(sar_busy),
      .sel_i(conv_ctrl_q[`ADCIM_CC_CLK_LO +: 2]),
      .tick_o(conv_tick)
   );
   adcim_sar u_sar
   (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .start_i(sar_start),
      .tick_i(conv_tick),
      .comp_i(comp_i),
      .trial_o(sar_trial),
      .busy_o(sar_busy),
      .done_o(sar_done),
      .result_o(sar_result)
   );
   always @*
   begin
      ch = conv_ctrl_q[`ADCIM_CC_CH_LO +: 3];
      flags_d = 8'h00;
      flags_d[`ADCIM_EM_PERIOD1] = period1_done_i & (~low_speed | slow_ok);
      flags_d[`ADCIM_EM_PERIOD2] = period2_done_i & (~low_speed | slow_ok);
      flags_d[`ADCIM_EM_SERIAL_RX] = serial_rx_full_i & (~low_speed | slow_ok);
      src_d = 8'h00;
      src_d[`ADCIM_SE_TICK] = tick_overflow_i;
      src_d[`ADCIM_SE_CNT_A] = counter_a_timeout_i;
      src_d[`ADCIM_SE_CNT_B] = counter_b_timeout_i;
      src_d[`ADCIM_SE_EDGE0] = edge0_hit;
      src_d[`ADCIM_SE_EDGE3] = edge3_hit;
   end
   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         conv_ctrl_q <= `ADCIM_RST_ZERO;
         event_mask_q <= `ADCIM_RST_ZERO;
         src_enable_q <= `ADCIM_RST_ZERO;
         control_q <= `ADCIM_RST_CONTROL;
         status_q <= `ADCIM_RST_ZERO;
         mode_q <= `ADCIM_RST_ZERO;
         gint_q <= 1'b0;
         conv_done_q <= 1'b0;
         done_prev_q <= 1'b0;
         edge0_prev_q <= 1'b0;
         edge3_prev_q <= 1'b0;
         rdata_o <= 8'h00;
         irq_o <= 1'b0;
         vector_addr_o <= 12'h000;
      end
      else
      begin
         edge0_prev_q <= edge_pin_0_i;
         edge3_prev_q <= edge_pin_3_i;
         done_prev_q <= conv_done_q;
         if (global_int_on_i)
            gint_q <= 1'b1;
         else if (global_int_off_i)
            gint_q <= 1'b0;
         if (wr_i)
         begin
            if (addr_i == `ADCIM_ADDR_CONV_CTRL)
               conv_ctrl_q <= wdata_i & 8'hfd;
            else if (addr_i == `ADCIM_ADDR_EVENT_MASK)
               event_mask_q <= wdata_i & 8'hf0;
            else if (addr_i == `ADCIM_ADDR_SRC_ENABLE)
               src_enable_q <= wdata_i;
            else if (addr_i == `ADCIM_ADDR_CONTROL)
               control_q <= wdata_i;
            else if (addr_i == `ADCIM_ADDR_MODE)
               mode_q <= wdata_i & 8'h1f;
         end
         // Hardware clears start at the end only when the completion mask is set.
         if (sar_done && mask_done && !start_wr)
            conv_ctrl_q[`ADCIM_CC_START] <= 1'b0;
         // Software clears status flags by writing 1; a new event wins over the clear.
         if (wr_i && addr_i == `ADCIM_ADDR_STATUS)
            status_q <= (status_q & ~wdata_i) | flags_d | {2'b00, sar_done & mask_done, 5'h00};
         else
            status_q <= status_q | flags_d | {2'b00, sar_done & mask_done, 5'h00};
         if (sar_done && mask_done)
            conv_done_q <= 1'b1;
         else if (wr_i && addr_i == `ADCIM_ADDR_STATUS && wdata_i[`ADCIM_EM_CONV_DONE])
            conv_done_q <= 1'b0;
         // Interrupt requests from masked events and enabled sources.
         if (gint_q && (|(src_d & src_enable_q) || |(flags_d & event_mask_q) ||
            (conv_done_q && !done_prev_q && mask_done && !low_speed)))
         begin
            irq_o <= 1'b1;
            vector_addr_o <= `ADCIM_VECTOR_ADDR;
         end
         else
            irq_o <= 1'b0;
         if (rd_i)
         begin
            if (addr_i == `ADCIM_ADDR_CONV_CTRL)
               rdata_o <= conv_ctrl_q;
            else if (addr_i == `ADCIM_ADDR_EVENT_MASK)
               rdata_o <= event_mask_q;
            else if (addr_i == `ADCIM_ADDR_SRC_ENABLE)
               rdata_o <= src_enable_q;
            else if (addr_i == `ADCIM_ADDR_CONTROL)
               rdata_o <= control_q;
            else if (addr_i == `ADCIM_ADDR_STATUS)
               rdata_o <= {status_q[7:6], conv_done_q, status_q[4:0]};
            else if (addr_i == `ADCIM_ADDR_RESULT)
               rdata_o <= sar_result;
            else if (addr_i == `ADCIM_ADDR_MODE)
               rdata_o <= mode_q;
            else
               rdata_o <= 8'h00;
         end
         else
            rdata_o <= 8'h00;
      end
   end
   always @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         dac_trial_o <= 8'h00;
         chan_en_o <= 4'h0;
         sample_hold_o <= 1'b0;
         bias_en_o <= 1'b0;
         ref_ext_sel_o <= 1'b0;
         port_conv_mode_o <= 1'b0;
      end
      else
      begin
         dac_trial_o <= sar_trial;
         if (ch >= 3'h2 && ch <= 3'h5)
            chan_en_o <= 4'h1 << (ch - 3'h2);
         else
            chan_en_o <= 4'h0;
         sample_hold_o <= sar_busy;
         bias_en_o <= conv_ctrl_q[`ADCIM_CC_POWER];
         ref_ext_sel_o <= ext_ref_i;
         port_conv_mode_o <= mode_q[`ADCIM_MODE_PORT_SW];
      end
   end
endmodule // adcim_top
`default_nettype wire

// file: dv/adcim_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcim_analog_model
(
   input wire logic [7:0] dac_trial_i,
   input wire logic [3:0] chan_en_i,
   input wire logic bias_en_i,
   output logic comp_o
);
   logic [7:0] level;
   always_comb
   begin
      case (chan_en_i)
         4'b0001: level = 8'h5a;
         4'b0010: level = 8'hc3;
         4'b0100: level = 8'h01;
         4'b1000: level = 8'hfe;
         default: level = 8'h00;
      endcase
      comp_o = bias_en_i && (|chan_en_i) && (level >= dac_trial_i);
   end
endmodule // adcim_analog_model
`default_nettype wire

// file: dv/adcim_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adcim_checker
(
   input wire clock_i,
   input wire rst_b_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire [7:0] dac_trial_o,
   input wire [3:0] chan_en_o,
   input wire sample_hold_o,
   input wire bias_en_o,
   input wire port_conv_mode_o,
   input wire irq_o,
   input wire [11:0] vector_addr_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   logic [11:0] hold_cnt_q;
   always_ff @(posedge clock_i or negedge rst_b_i)
      if (!rst_b_i)
         hold_cnt_q <= 12'h000;
      else
         hold_cnt_q <= sample_hold_o ? hold_cnt_q + 12'h001 : 12'h000;
   rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside read slot");
   unmapped_read_a: assert property (rd_i && addr_i > 4'h6 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   power_follow_a: assert property (wr_i && addr_i == 4'h0 |-> ##2 bias_en_o == $past(wdata_i[2], 2))
      else $error("bias enable does not follow power bit");
   port_mode_a: assert property (wr_i && addr_i == 4'h6 |-> ##2 port_conv_mode_o == $past(wdata_i[4], 2))
      else $error("port mode does not follow switch bit");
   chan_onehot_a: assert property ($onehot0(chan_en_o))
      else $error("more than one channel enabled");
   vector_hold_a: assert property ($past(irq_o) |-> vector_addr_o == 12'h008)
      else $error("vector address wrong after interrupt");
   conv_len_a: assert property ($fell(sample_hold_o) |-> hold_cnt_q >= 12'd130)
      else $error("conversion shorter than allowed");
   trial_idle_a: assert property (!sample_hold_o && !$past(sample_hold_o) && !$past(sample_hold_o, 2)
      && !$past(sample_hold_o, 3) |-> $stable(dac_trial_o))
      else $error("trial word moves while idle");
endmodule // adcim_checker
bind adcim_top adcim_checker i_adcim_checker (.clock_i(clock_i), .rst_b_i(rst_b_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .dac_trial_o(dac_trial_o), .chan_en_o(chan_en_o), .sample_hold_o(sample_hold_o),
   .bias_en_o(bias_en_o), .port_conv_mode_o(port_conv_mode_o), .irq_o(irq_o),
   .vector_addr_o(vector_addr_o));
`default_nettype wire

// file: dv/adcim_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adcim_top_tb;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] ev = 8'h00;
   logic [1:0] pin = 2'b00;
   logic ext_ref_i = 1'b1;
   logic comp_i, bias_en_o, sample_hold_o, ref_ext_sel_o, port_conv_mode_o, irq_o;
   logic [7:0] rdata_o, dac_trial_o;
   logic [3:0] chan_en_o;
   logic [11:0] vector_addr_o;
   logic [7:0] bits [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h40, 8'h80};
   logic [7:0] lv [4] = '{8'h5a, 8'hc3, 8'h01, 8'hfe};
   int err_total = 0;
   int check_count = 0;
   int n;
   adcim_top i_adcim_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .comp_i(comp_i),
      .ext_ref_i(ext_ref_i), .tick_overflow_i(ev[0]), .counter_a_timeout_i(ev[1]),
      .counter_b_timeout_i(ev[2]), .period1_done_i(ev[3]), .serial_rx_full_i(ev[4]),
      .period2_done_i(ev[5]), .global_int_on_i(ev[6]), .global_int_off_i(ev[7]),
      .edge_pin_0_i(pin[0]), .edge_pin_3_i(pin[1]), .dac_trial_o(dac_trial_o),
      .chan_en_o(chan_en_o), .sample_hold_o(sample_hold_o), .bias_en_o(bias_en_o),
      .ref_ext_sel_o(ref_ext_sel_o), .port_conv_mode_o(port_conv_mode_o), .irq_o(irq_o),
      .vector_addr_o(vector_addr_o));
   adcim_analog_model i_adcim_analog_model (.dac_trial_i(dac_trial_o), .chan_en_i(chan_en_o),
      .bias_en_i(bias_en_o), .comp_o(comp_i));
   initial
      forever #50 clock_i = ~clock_i;
   task wrap_up;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [11:0] g, input logic [11:0] e);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      chk({4'h0, rdata_o}, {4'h0, e});
   endtask
   task pulse(input int i);
      @(posedge clock_i);
      ev[i] <= 1'b1;
      @(posedge clock_i);
      ev[i] <= 1'b0;
   endtask
   task irq_w(input int lim, input logic e);
      n = 0;
      #1;
      while (n < lim && irq_o !== 1'b1)
      begin
         @(posedge clock_i);
         #1;
         n++;
      end
      chk({11'h0, n < lim}, {11'h0, e});
      if (e && n >= lim)
         wrap_up;
   endtask
   task edge_step(input int p, input logic v, input logic e);
      @(posedge clock_i);
      pin[p] <= v;
      irq_w(6, e);
   endtask
   task t_reset;
      rd(4'h3, 8'hff);
      chk({11'h0, ref_ext_sel_o}, 12'h001);
      rd(4'h1, 8'h00);
      wr(4'h9, 8'hff);
      rd(4'h9, 8'h00);
      wr(4'h1, 8'hf0);
      rd(4'h1, 8'hf0);
      wr(4'h2, 8'h8f);
      rd(4'h2, 8'h8f);
      $display("test reset and registers done");
   endtask
   task t_conv;
      wr(4'h2, 8'h00);
      wr(4'h6, 8'h10);
      pulse(6);
      wr(4'h1, 8'h20);
      for (int s = 0; s < 4; s++)
      begin
         wr(4'h0, {s[2:0] + 3'h2, s[1:0], 3'h5});
         if (s == 0)
         begin
            rd(4'h5, 8'h00);
            repeat (38) @(posedge clock_i);
            wr(4'h0, 8'h45);
         end
         irq_w(1200, 1'b1);
         if (s == 0)
            n = n + 42;
         chk({11'h0, n >= (132 << s) && n <= (132 << s) + 8}, 12'h001);
         chk({8'h0, chan_en_o}, 12'h001 << s);
         rd(4'h5, lv[s]);
         rd(4'h4, 8'h20);
         rd(4'h0, {s[2:0] + 3'h2, s[1:0], 3'h4});
         wr(4'h4, 8'h20);
         rd(4'h4, 8'h00);
      end
      chk(vector_addr_o, 12'h008);
      $display("test single conversions done");
   endtask
   task t_control_reg;
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h45);
      irq_w(400, 1'b0);
      rd(4'h0, 8'h45);
      rd(4'h4, 8'h00);
      wr(4'h1, 8'h20);
      irq_w(300, 1'b1);
      rd(4'h4, 8'h20);
      wr(4'h4, 8'h20);
      wr(4'h0, 8'h40);
      repeat (3) @(posedge clock_i);
      #1;
      chk({11'h0, bias_en_o}, 12'h000);
      $display("test continuous conversion done");
   endtask
   task t_src;
      logic [3:0] a;
      for (int i = 0; i < 6; i++)
      begin
         a = i < 3 ? 4'h2 : 4'h1;
         wr(a, bits[i]);
         pulse(i);
         irq_w(6, 1'b1);
         wr(a, 8'h00);
         pulse(i);
         irq_w(6, 1'b0);
      end
      pulse(7);
      wr(4'h2, 8'h01);
      pulse(0);
      irq_w(6, 1'b0);
      pulse(6);
      pulse(0);
      irq_w(6, 1'b1);
      wr(4'h2, 8'h88);
      wr(4'h3, 8'h80);
      edge_step(0, 1'b1, 1'b1);
      edge_step(0, 1'b0, 1'b0);
      wr(4'h3, 8'h00);
      edge_step(0, 1'b1, 1'b0);
      edge_step(0, 1'b0, 1'b1);
      edge_step(1, 1'b1, 1'b0);
      edge_step(1, 1'b0, 1'b1);
      wr(4'h4, 8'hff);
      wr(4'h6, 8'h12);
      wr(4'h1, 8'h30);
      wr(4'h0, 8'h45);
      irq_w(200, 1'b0);
      rd(4'h4, 8'h20);
      pulse(3);
      irq_w(6, 1'b0);
      wr(4'h6, 8'h1e);
      pulse(3);
      irq_w(6, 1'b1);
      $display("test interrupt sources done");
   endtask
   initial
   begin
      repeat (4) @(posedge clock_i);
      rst_b_i <= 1'b1;
      t_reset;
      t_conv;
      t_control_reg;
      t_src;
      wrap_up;
   end
endmodule // adcim_top_tb
`default_nettype wire
